// [design/usr_pkg.sv]
package usr_pkg;
   // number of stages
   localparam int USR_STAGES = 4;
   // every stage empty after clear
   localparam logic [USR_STAGES-1:0] USR_CLEAR_VALUE = 4'h0;
   // index of the stage that takes the right serial input
   localparam int USR_FIRST_STAGE = 0;

   typedef enum logic [1:0] {
      USR_HOLD,
      USR_SHIFT_RIGHT,
      USR_SHIFT_LEFT,
      USR_LOAD
   } usr_mode_e;
endpackage : usr_pkg

// [design/usr_stage_sel.sv]
`timescale 1ns/1ps
`default_nettype none
module usr_stage_sel
   import usr_pkg::*;
(
   // operation for this edge
   input wire usr_mode_e mode,
   // candidate sources
   input wire logic current,
   input wire logic from_lower,
   input wire logic from_upper,
   input wire logic parallel,
   // chosen next value
   output logic next_bit
);
   always_comb begin
      unique case (mode)
         USR_HOLD: next_bit = current;
         USR_SHIFT_RIGHT: next_bit = from_lower;
         USR_SHIFT_LEFT: next_bit = from_upper;
         // serial neighbours not consulted here
         USR_LOAD: next_bit = parallel;
      endcase
   end
endmodule : usr_stage_sel
`default_nettype wire

// [design/usr_shift_reg.sv]
// Overview of operation
// - The register has four stages, each with its own parallel input and its own always-driven output.
// - With both mode selects high and clear inactive, each stage loads its parallel input on the rising edge.
// - During a parallel load both serial inputs are ignored.
// - Low select 1, high select 0 shifts from stage 0 toward stage 3 with the right serial input entering stage 0.
// - Low select 0, high select 1 shifts from stage 3 toward stage 0 with the left serial input entering stage 3.
// - Shifts happen only on the rising clock edge, taking the serial input of the selected direction.
// - With both mode selects low and clear inactive, the contents are held.
// - While clear is low every stage and output is forced low at once, without a clock edge.
// - Clear overrides the clock and both mode selects.
`timescale 1ns/1ps
`default_nettype none
module usr_shift_reg
   import usr_pkg::*;
#(
   parameter int WIDTH = USR_STAGES
)
(
   // clock and active-low clear
   input wire logic MCLK,
   input wire logic ARST_N,
   // mode selects
   input wire logic MODE_SELECT_LOW,
   input wire logic MODE_SELECT_HIGH,
   // serial inputs
   input wire logic RIGHT_SERIAL_IN,
   input wire logic LEFT_SERIAL_IN,
   // parallel data in, bit 0 is the first stage
   input wire logic [WIDTH-1:0] PARALLEL_IN,
   // stage outputs, bit 0 is the first stage
   output logic [WIDTH-1:0] STAGE_OUT
);
   typedef struct packed {
      logic [WIDTH-1:0] stage;
   } usr_state_s;

   usr_state_s state;
   usr_state_s next_state;
   usr_mode_e mode;
   logic [WIDTH-1:0] next_stage;
   // neighbours padded with the serial inputs at either end
   logic [WIDTH+1:0] chain;

   // inputs are synchronous, so the decode can feed the flops directly
   always_comb begin
      unique case ({MODE_SELECT_HIGH, MODE_SELECT_LOW})
         2'h0: mode = USR_HOLD;
         2'h1: mode = USR_SHIFT_RIGHT;
         2'h2: mode = USR_SHIFT_LEFT;
         2'h3: mode = USR_LOAD;
      endcase
   end

   // right serial enters below stage 0, left serial above the last
   assign chain = {LEFT_SERIAL_IN, state.stage, RIGHT_SERIAL_IN};

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_stage
         usr_stage_sel u_sel (
            .mode(mode),
            .current(state.stage[gi]),
            .from_lower(chain[gi]),
            .from_upper(chain[gi+2]),
            .parallel(PARALLEL_IN[gi]),
            .next_bit(next_stage[gi])
         );
      end
   endgenerate

   always_comb begin
      next_state = state;
      next_state.stage = next_stage;
   end

   // clear is the async reset, so it beats clock and mode alike
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= '{stage: WIDTH'(USR_CLEAR_VALUE)};
      end else begin
         state <= next_state;
      end
   end

   // outputs come straight from the stage flops
   assign STAGE_OUT = state.stage;

   // checks

   property p_load;
      @(posedge MCLK) disable iff (!ARST_N)
      mode == USR_LOAD |=> STAGE_OUT == $past(PARALLEL_IN);
   endproperty
   a_load: assert property (p_load)
      else $error("parallel load did not capture data");

   property p_load_no_serial;
      @(posedge MCLK) disable iff (!ARST_N)
      (mode == USR_LOAD && RIGHT_SERIAL_IN != PARALLEL_IN[0]
         && LEFT_SERIAL_IN != PARALLEL_IN[WIDTH-1])
      |=> STAGE_OUT[0] == $past(PARALLEL_IN[0])
         && STAGE_OUT[WIDTH-1] == $past(PARALLEL_IN[WIDTH-1]);
   endproperty
   a_load_no_serial: assert property (p_load_no_serial)
      else $error("serial data leaked into a parallel load");

   property p_shift_right;
      @(posedge MCLK) disable iff (!ARST_N)
      mode == USR_SHIFT_RIGHT
      |=> STAGE_OUT == {$past(STAGE_OUT[WIDTH-2:0]), $past(RIGHT_SERIAL_IN)};
   endproperty
   a_shift_right: assert property (p_shift_right)
      else $error("shift right result wrong");

   property p_shift_left;
      @(posedge MCLK) disable iff (!ARST_N)
      mode == USR_SHIFT_LEFT
      |=> STAGE_OUT == {$past(LEFT_SERIAL_IN), $past(STAGE_OUT[WIDTH-1:1])};
   endproperty
   a_shift_left: assert property (p_shift_left)
      else $error("shift left result wrong");

   // a serial one walked in from the right reaches the last stage
   sequence s_walk_right;
      (mode == USR_SHIFT_RIGHT && RIGHT_SERIAL_IN) ##1
      (mode == USR_SHIFT_RIGHT) [*3];
   endsequence
   property p_walk_right;
      @(posedge MCLK) disable iff (!ARST_N)
      s_walk_right |=> STAGE_OUT[WIDTH-1];
   endproperty
   a_walk_right: assert property (p_walk_right)
      else $error("serial bit did not walk through four stages");

   // the mirror walk catches a swapped serial pair
   sequence s_walk_left;
      (mode == USR_SHIFT_LEFT && LEFT_SERIAL_IN) ##1
      (mode == USR_SHIFT_LEFT) [*3];
   endsequence
   property p_walk_left;
      @(posedge MCLK) disable iff (!ARST_N)
      s_walk_left |=> STAGE_OUT[0];
   endproperty
   a_walk_left: assert property (p_walk_left)
      else $error("serial bit did not walk down to the first stage");

   property p_change_needs_mode;
      @(posedge MCLK) disable iff (!ARST_N)
      ($past(ARST_N) && STAGE_OUT != $past(STAGE_OUT))
      |-> $past(mode) != USR_HOLD;
   endproperty
   a_change_needs_mode: assert property (p_change_needs_mode)
      else $error("stages changed while holding");

   property p_hold;
      @(posedge MCLK) disable iff (!ARST_N)
      (mode == USR_HOLD) [*2]
      |=> $stable(STAGE_OUT) && STAGE_OUT == $past(STAGE_OUT, 2);
   endproperty
   a_hold: assert property (p_hold)
      else $error("contents moved during hold");

   // no disable here: these watch the clear itself
   property p_clear_rise;
      @(posedge MCLK) !ARST_N |-> STAGE_OUT == USR_CLEAR_VALUE;
   endproperty
   a_clear_rise: assert property (p_clear_rise)
      else $error("outputs not low during clear");

   property p_clear_fall;
      @(negedge MCLK) !ARST_N |-> STAGE_OUT == USR_CLEAR_VALUE;
   endproperty
   a_clear_fall: assert property (p_clear_fall)
      else $error("clear did not act without a rising edge");

   property p_clear_beats_load;
      @(posedge MCLK)
      (!ARST_N && mode == USR_LOAD) ##1 !ARST_N |-> STAGE_OUT == USR_CLEAR_VALUE;
   endproperty
   a_clear_beats_load: assert property (p_clear_beats_load)
      else $error("load acted through clear");

   property p_resume;
      @(posedge MCLK)
      ($rose(ARST_N) && mode == USR_LOAD) |=> STAGE_OUT == $past(PARALLEL_IN);
   endproperty
   a_resume: assert property (p_resume)
      else $error("no load on first edge after clear");

   // nothing may move before the first edge that sees clear released
   property p_clear_clean;
      @(posedge MCLK) $rose(ARST_N) |-> STAGE_OUT == USR_CLEAR_VALUE;
   endproperty
   a_clear_clean: assert property (p_clear_clean)
      else $error("stages not empty when clear was released");

   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_chk
         property p_stage_load;
            @(posedge MCLK) disable iff (!ARST_N)
            mode == USR_LOAD |=> STAGE_OUT[gi] == $past(PARALLEL_IN[gi]);
         endproperty
         a_stage_load: assert property (p_stage_load)
            else $error("stage did not take its own input");

         property p_stage_hold;
            @(posedge MCLK) disable iff (!ARST_N)
            mode == USR_HOLD |=> $stable(STAGE_OUT[gi]);
         endproperty
         a_stage_hold: assert property (p_stage_hold)
            else $error("stage moved during hold");
      end
   endgenerate

   c_load: cover property (@(posedge MCLK) disable iff (!ARST_N)
      mode == USR_LOAD ##1 mode == USR_HOLD);
   c_right: cover property (@(posedge MCLK) disable iff (!ARST_N)
      s_walk_right);
   c_left: cover property (@(posedge MCLK) disable iff (!ARST_N)
      (mode == USR_SHIFT_LEFT) [*4]);
   c_clear_in_load: cover property (@(posedge MCLK)
      !ARST_N && mode == USR_LOAD ##1 ARST_N);
   c_resume: cover property (@(posedge MCLK)
      $rose(ARST_N) && mode == USR_LOAD);
endmodule : usr_shift_reg
`default_nettype wire

// [tb/usr_far_logic.sv]
`timescale 1ns/1ps
`default_nettype none
module usr_far_logic
   import usr_pkg::*;
(
   // clock
   input wire logic MCLK,
   // controls and data toward the register
   output var logic sel_low = 1'h0,
   output var logic sel_high = 1'h0,
   output var logic ser_r = 1'h0,
   output var logic ser_l = 1'h0,
   output var logic [USR_STAGES-1:0] par = 4'h0
);
   // par and, outside the shifts, both serial lines wander, so a stray read shows up
   task automatic step(input usr_mode_e m, input logic r, input logic l,
                       input logic [USR_STAGES-1:0] d);
      @(posedge MCLK);
      sel_low <= m[0];
      sel_high <= m[1];
      par <= (m == USR_LOAD) ? d : ~par;
      if (m == USR_SHIFT_RIGHT || m == USR_SHIFT_LEFT) begin
         ser_r <= r;
         ser_l <= l;
      end else begin
         ser_r <= ~ser_r;
         ser_l <= ~ser_l;
      end
   endtask : step
endmodule : usr_far_logic
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   import usr_pkg::*;
   logic MCLK = 1'h0;
   // driven low at time zero so the clear sees a falling edge
   logic ARST_N;
   logic sel_low, sel_high, ser_r, ser_l;
   logic [USR_STAGES-1:0] par, q, exp;
   int miscompares = 0;
   int samples_checked = 0;
   initial begin
      forever #4 MCLK = ~MCLK;
   end
   usr_far_logic far (.MCLK(MCLK), .sel_low(sel_low), .sel_high(sel_high),
      .ser_r(ser_r), .ser_l(ser_l), .par(par));
   usr_shift_reg #(.WIDTH(USR_STAGES)) dut (.MCLK(MCLK), .ARST_N(ARST_N),
      .MODE_SELECT_LOW(sel_low), .MODE_SELECT_HIGH(sel_high),
      .RIGHT_SERIAL_IN(ser_r), .LEFT_SERIAL_IN(ser_l),
      .PARALLEL_IN(par), .STAGE_OUT(q));
   task automatic end_of_test;
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic cmp(input logic [USR_STAGES-1:0] got,
                      input logic [USR_STAGES-1:0] want);
      samples_checked++;
      if (got !== want) begin
         miscompares++;
         $display("Error at %0t got %h want %h", $time, got, want);
      end
   endtask : cmp
   // checks the previous edge's result, then predicts this one
   task automatic op(input usr_mode_e m, input logic r, input logic l,
                     input logic [USR_STAGES-1:0] d);
      far.step(m, r, l, d);
      #1;
      cmp(q, exp);
      case (m)
         USR_SHIFT_RIGHT: exp = {exp[2:0], r};
         USR_SHIFT_LEFT: exp = {l, exp[3:1]};
         USR_LOAD: exp = d;
         default: exp = exp;
      endcase
   endtask : op
   task automatic t_shift(input usr_mode_e m, input logic [3:0] pat);
      for (int i = 0; i < USR_STAGES; i++) begin
         op(m, pat[i] ^ (m == USR_SHIFT_LEFT),
            pat[i] ^ (m == USR_SHIFT_RIGHT), 4'h0);
      end
   endtask : t_shift
   // clear lands while a load is pending, held across edges
   task automatic t_clear;
      far.step(USR_LOAD, 1'h0, 1'h0, 4'h9);
      ARST_N <= 1'h0;
      #1;
      cmp(q, USR_CLEAR_VALUE);
      repeat (2) @(posedge MCLK);
      #1;
      cmp(q, USR_CLEAR_VALUE);
      @(posedge MCLK);
      ARST_N <= 1'h1;
      exp = 4'h9;
   endtask : t_clear
   initial begin
      ARST_N <= 1'h0;
      exp = USR_CLEAR_VALUE;
      repeat (5) @(posedge MCLK);
      cmp(q, USR_CLEAR_VALUE);
      ARST_N <= 1'h1;
      op(USR_LOAD, 1'h1, 1'h1, 4'hA);
      op(USR_LOAD, 1'h1, 1'h1, 4'h5);
      t_shift(USR_SHIFT_RIGHT, 4'hD);
      t_shift(USR_SHIFT_LEFT, 4'hB);
      op(USR_HOLD, 1'h1, 1'h0, 4'hF);
      op(USR_HOLD, 1'h0, 1'h1, 4'h0);
      t_clear();
      op(USR_SHIFT_RIGHT, 1'h1, 1'h0, 4'h0);
      op(USR_HOLD, 1'h0, 1'h0, 4'h0);
      op(USR_HOLD, 1'h0, 1'h0, 4'h0);
      op(USR_LOAD, 1'h0, 1'h1, 4'hC);
      op(USR_HOLD, 1'h1, 1'h1, 4'h0);
      op(USR_HOLD, 1'h0, 1'h0, 4'h0);
      end_of_test();
   end
   // the run needs well under a hundred cycles
   initial begin
      #(1000 * 8);
      miscompares++;
      end_of_test();
   end
endmodule : tb
`default_nettype wire
